//--- logic/fpec_top.v
// Flash array control: APB registers, erase and page program sequencing
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "fpec_regs.vh"
module fpec_top (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [17:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [7:0]  protect_byte,
	output reg         high_voltage_on,
	output wire        pump_tick
);
	// Nonvolatile array; never reset, contents survive reset
	// Bytes never erased or programmed read as unknown in simulation
	reg  [7:0]  arr [0:32767];
	reg  [7:0]  pbuf [0:7];

	reg         program_select;
	reg         erase_select;
	reg         margin_select;
	reg         high_voltage_enable;
	reg  [1:0]  block_size;
	reg  [1:0]  pump_divider;

	reg  [7:0]  prot_latch;
	reg         prot_seen;
	reg  [14:0] tgt_addr;
	reg         tgt_seen;
	reg  [7:0]  page_mask;
	reg         refused;
	reg         walk;
	reg  [14:0] wptr;
	reg         hv_d;
	reg  [3:0]  wait_cnt;

	wire [15:0] idx;
	wire        access;
	wire        done;
	wire        hit_ctrl;
	wire        hit_stat;
	wire        hit_prot;
	wire        hit_user;
	wire        mapped;
	wire [3:0]  need;
	wire [7:0]  wd;
	wire [7:0]  ctrl_val;
	wire [7:0]  stat_val;
	wire        ctrl_wr;
	wire        user_wr;
	wire        hv_rise;
	wire        page_ld;
	wire        blk_ld;

	reg  [31:0] rd_val;
	reg  [14:0] tgt_lo;
	reg  [14:0] tgt_hi;
	reg  [14:0] bound;
	reg         any_prot;
	reg         overlap;
	reg         next_program_select;
	reg         next_erase_select;
	reg         next_margin_select;
	reg         next_high_voltage_enable;
	reg         next_refused_set;

	function in_user;
		input [15:0] a;
		begin
			in_user = (a >= `FPEC_WIN0_LO && a <= `FPEC_WIN0_HI) ||
			          (a >= `FPEC_WIN1_LO && a <= `FPEC_WIN1_HI) ||
			          (a >= `FPEC_WIN2_LO && a <= `FPEC_WIN2_HI);
		end
	endfunction

	// Printed offsets are word indices; byte address is four times that
	assign idx      = paddr[17:2];
	assign hit_ctrl = (idx == `FPEC_IDX_CTRL);
	assign hit_stat = (idx == `FPEC_IDX_STAT);
	assign hit_prot = (idx == `FPEC_IDX_PROT);
	assign hit_user = in_user(idx);
	// Unmapped indices answer with an error and change nothing
	assign mapped   = hit_ctrl | hit_stat | hit_prot | hit_user;
	assign access   = psel & penable;
	assign done     = access & pready;
	assign wd       = pwdata[7:0];
	assign ctrl_wr  = done & pwrite & hit_ctrl;
	assign user_wr  = done & pwrite & hit_user;
	assign hv_rise  = high_voltage_enable & ~hv_d;

	// Array writes only latch a target while high voltage is off,
	// so the target address cannot move under a running walker
	assign page_ld  = user_wr & ~high_voltage_enable & program_select;
	assign blk_ld   = user_wr & ~high_voltage_enable & erase_select;

	// Margin reads of the array wait eight cycles longer
	assign need = (margin_select & hit_user & ~pwrite) ?
	              `FPEC_MARGIN_WAIT : 4'h0;

	// Field order follows the control register layout
	assign ctrl_val = {pump_divider[1], pump_divider[0],
	                   block_size[1], block_size[0],
	                   high_voltage_enable, margin_select,
	                   erase_select, program_select};
	// Status shows sequence progress; only refused can be cleared
	assign stat_val = {4'h0, refused, tgt_seen, prot_seen, walk};

	// Every register is one byte wide; upper bytes read as zero
	always @* begin
		rd_val = 32'h0000_0000;
		if (hit_ctrl)
			rd_val = {24'h000000, ctrl_val};
		else if (hit_stat)
			rd_val = {24'h000000, stat_val};
		else if (hit_prot)
			rd_val = {24'h000000, protect_byte};
		else if (hit_user)
			rd_val = {24'h000000, arr[idx[14:0]]};
	end

	// Address range of the pending operation
	// Program mode covers one page whatever the block size field holds
	always @* begin
		tgt_lo = tgt_addr;
		tgt_hi = tgt_addr;
		if (program_select) begin
			tgt_lo = {tgt_addr[14:3], 3'h0};
			tgt_hi = {tgt_addr[14:3], 3'h7};
		end else begin
			case (block_size)
			`FPEC_BLK_FULL: begin
				tgt_lo = 15'h0000;
				tgt_hi = 15'h7FFF;
			end
			`FPEC_BLK_HALF: begin
				tgt_lo = {tgt_addr[14], 14'h0000};
				tgt_hi = {tgt_addr[14], 14'h3FFF};
			end
			`FPEC_BLK_EIGHT: begin
				tgt_lo = {tgt_addr[14:9], 9'h000};
				tgt_hi = {tgt_addr[14:9], 9'h1FF};
			end
			`FPEC_BLK_ROW: begin
				tgt_lo = {tgt_addr[14:6], 6'h00};
				tgt_hi = {tgt_addr[14:6], 6'h3F};
			end
			default: begin
				tgt_lo = tgt_addr;
				tgt_hi = tgt_addr;
			end
			endcase
		end
	end

	// Every protected range runs up to the top of the array,
	// so overlap only needs the lowest protected address
	always @* begin
		any_prot = |prot_latch[3:0];
		bound    = `FPEC_PROT_B3;
		if (prot_latch[0])
			bound = `FPEC_PROT_B0;
		else if (prot_latch[1])
			bound = `FPEC_PROT_B1;
		else if (prot_latch[2])
			bound = `FPEC_PROT_B2;
		overlap = any_prot & (tgt_hi >= bound);
	end

	// Control register write with its interlocks
	// High voltage already on stays on while a write keeps it set with either mode selected
	always @* begin
		next_program_select      = wd[`FPEC_BIT_PGM];
		next_erase_select        = wd[`FPEC_BIT_ERASE];
		next_refused_set         = 1'b0;
		// A write asking for both modes changes neither
		if (wd[`FPEC_BIT_PGM] & wd[`FPEC_BIT_ERASE]) begin
			next_program_select = program_select;
			next_erase_select   = erase_select;
			next_refused_set    = 1'b1;
		end
		next_high_voltage_enable = 1'b0;
		if (wd[`FPEC_BIT_HIGH_VOLTAGE_ENABLE] &
		    (next_program_select | next_erase_select)) begin
			if (high_voltage_enable)
				next_high_voltage_enable = 1'b1;
			else if (prot_seen & tgt_seen & overlap) begin
				next_program_select = 1'b0;
				next_erase_select   = 1'b0;
				next_refused_set    = 1'b1;
			end else if (prot_seen & tgt_seen)
				next_high_voltage_enable = 1'b1;
			else
				next_refused_set = 1'b1;
		end else if (wd[`FPEC_BIT_HIGH_VOLTAGE_ENABLE])
			next_refused_set = 1'b1;
		next_margin_select = wd[`FPEC_BIT_MARGIN] &
		                     ~high_voltage_enable &
		                     ~next_high_voltage_enable;
		if (wd[`FPEC_BIT_MARGIN] & ~next_margin_select)
			next_refused_set = 1'b1;
	end

	// APB slave: one wait state, nine on a margin read
	// pready drops for a cycle after each answer, so a master that
	// starts its next setup at once is never answered twice
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
			wait_cnt <= 4'h0;
		end else if (pready) begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (access) begin
			if (wait_cnt == need) begin
				pready  <= 1'b1;
				pslverr <= ~mapped;
				prdata  <= pwrite ? 32'h0000_0000 : rd_val;
			end else
				wait_cnt <= wait_cnt + 4'h1;
		end
	end

	// Control register and sequence tracking
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			program_select      <= 1'b0;
			erase_select        <= 1'b0;
			margin_select       <= 1'b0;
			high_voltage_enable <= 1'b0;
			block_size          <= 2'h0;
			pump_divider        <= 2'h0;
			high_voltage_on     <= 1'b0;
			hv_d                <= 1'b0;
			prot_latch          <= 8'h00;
			prot_seen           <= 1'b0;
			tgt_seen            <= 1'b0;
			tgt_addr            <= 15'h0000;
			page_mask           <= 8'h00;
			refused             <= 1'b0;
		end else begin
			hv_d            <= high_voltage_enable;
			high_voltage_on <= high_voltage_enable;
			if (ctrl_wr) begin
				program_select      <= next_program_select;
				erase_select        <= next_erase_select;
				margin_select       <= next_margin_select;
				high_voltage_enable <= next_high_voltage_enable;
				// Divider and block size take any code; all four are decoded
				block_size   <= {wd[`FPEC_BIT_BLOCK_SIZE_HIGH], wd[`FPEC_BIT_BLOCK_SIZE_LOW]};
				pump_divider <= {wd[`FPEC_BIT_DIV1], wd[`FPEC_BIT_DIV0]};
				// Entering or leaving a mode restarts its sequence
				if ((next_program_select != program_select) ||
				    (next_erase_select != erase_select)) begin
					prot_seen <= 1'b0;
					tgt_seen  <= 1'b0;
					page_mask <= 8'h00;
				end
			end
			// Latching only inside a mode keeps a stray protect read
			// from arming a later sequence
			if (done & ~pwrite & hit_prot &
			    (program_select | erase_select)) begin
				prot_latch <= prdata[7:0];
				prot_seen  <= 1'b1;
			end
			if (blk_ld) begin
				tgt_addr <= idx[14:0];
				tgt_seen <= 1'b1;
			end
			if (page_ld) begin
				tgt_addr <= idx[14:0];
				tgt_seen <= 1'b1;
				// A write to another page starts a fresh page
				if (tgt_seen && (idx[14:3] == tgt_addr[14:3]))
					page_mask[idx[2:0]] <= 1'b1;
				else
					page_mask <= 8'h01 << idx[2:0];
			end
			// Set wins over the write-one clear
			if (ctrl_wr & next_refused_set)
				refused <= 1'b1;
			else if (done & pwrite & hit_stat &
			         wd[`FPEC_ST_REFUSED])
				refused <= 1'b0;
		end
	end

	// Walker applies an erase or a page program while high voltage is on
	// Clearing high voltage mid-walk leaves the rest of the range as it
	// was, so software must allow the full erase or program time
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			walk <= 1'b0;
			wptr <= 15'h0000;
		end else if (!high_voltage_enable) begin
			walk <= 1'b0;
		end else if (hv_rise) begin
			walk <= 1'b1;
			wptr <= tgt_lo;
		end else if (walk) begin
			if (wptr == tgt_hi)
				walk <= 1'b0;
			else
				wptr <= wptr + 15'h0001;
		end
	end

	// Page buffer holds latched program data until high voltage
	always @(posedge sys_clk) begin
		if (page_ld)
			pbuf[idx[2:0]] <= wd;
	end

	// Program only sets bits; erase returns bytes to zero
	// The hv_rise edge is skipped while the walker pointer is loading
	always @(posedge sys_clk) begin
		if (walk & high_voltage_enable & ~hv_rise &
		    in_user({1'b0, wptr})) begin
			if (erase_select)
				arr[wptr] <= `FPEC_ERASED_BYTE;
			else if (program_select & page_mask[wptr[2:0]])
				arr[wptr] <= arr[wptr] | pbuf[wptr[2:0]];
		end
	end

	// The pump clock only runs while high voltage is on
	fpec_pump_div u_pump (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.run     (high_voltage_enable),
		.code    (pump_divider),
		.tick    (pump_tick)
	);
endmodule

//--- logic/fpec_regs.vh
// Register map, field positions and timing counts of the flash array control
`ifndef FPEC_REGS_VH
`define FPEC_REGS_VH

`define FPEC_IDX_CTRL      16'hFE11
`define FPEC_IDX_STAT      16'hFE12
`define FPEC_IDX_PROT      16'hFF81

`define FPEC_WIN0_LO       16'h0450
`define FPEC_WIN0_HI       16'h04FF
`define FPEC_WIN1_LO       16'h0580
`define FPEC_WIN1_HI       16'h05FF
`define FPEC_WIN2_LO       16'h0E00
`define FPEC_WIN2_HI       16'h7FFF

`define FPEC_BIT_PGM       0
`define FPEC_BIT_ERASE     1
`define FPEC_BIT_MARGIN    2
`define FPEC_BIT_HIGH_VOLTAGE_ENABLE      3
`define FPEC_BIT_BLOCK_SIZE_LOW      4
`define FPEC_BIT_BLOCK_SIZE_HIGH      5
`define FPEC_BIT_DIV0      6
`define FPEC_BIT_DIV1      7

`define FPEC_ST_BUSY       0
`define FPEC_ST_PROT_SEEN  1
`define FPEC_ST_TGT_SEEN   2
`define FPEC_ST_REFUSED    3

`define FPEC_CTRL_RESET    8'h00

`define FPEC_BLK_FULL      2'h0
`define FPEC_BLK_HALF      2'h1
`define FPEC_BLK_EIGHT     2'h2
`define FPEC_BLK_ROW       2'h3

`define FPEC_PROT_B0       15'h0450
`define FPEC_PROT_B1       15'h1000
`define FPEC_PROT_B2       15'h2000
`define FPEC_PROT_B3       15'h4000

`define FPEC_MARGIN_WAIT   4'h8
`define FPEC_ERASED_BYTE   8'h00

`endif

//--- logic/fpec_pump_div.v
// Charge pump clock divider producing one tick per pump clock period
`timescale 1ns/1ns
module fpec_pump_div (
	input  wire       sys_clk,
	input  wire       rst_b,
	input  wire       run,
	input  wire [1:0] code,
	output reg        tick
);
	reg  [1:0] cnt;
	wire [1:0] last;

	// Codes 01 and 10 both divide by two
	assign last = (code == 2'h0) ? 2'h0 :
	              (code == 2'h3) ? 2'h3 : 2'h1;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt  <= 2'h0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt  <= 2'h0;
			tick <= 1'b0;
		end else begin
			tick <= (cnt == 2'h0);
			if (cnt >= last)
				cnt <= 2'h0;
			else
				cnt <= cnt + 2'h1;
		end
	end
endmodule

//--- verification/fpec_properties.sv
// Bus, interlock and pump clock checks for the flash array control block
`timescale 1ns/1ns
module fpec_properties (
	input wire        sys_clk,
	input wire        rst_b,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [17:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [7:0]  protect_byte,
	input wire        high_voltage_on,
	input wire        pump_tick
);
	wire [15:0] i = paddr[17:2];
	wire        usr = (i >= 16'h0450 && i <= 16'h04FF) ||
		(i >= 16'h0580 && i <= 16'h05FF) || (i >= 16'h0E00 && i <= 16'h7FFF);
	wire        ok = usr || i == 16'hFE11 || i == 16'hFE12 || i == 16'hFF81;
	wire        rdc = pready && !pwrite && i == 16'hFE11;
	reg  [3:0]  wcnt;
	reg  [1:0]  div;
	// Divider mirror: the interlocks never touch these two bits
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wcnt <= 4'h0;
			div <= 2'h0;
		end else begin
			wcnt <= pready ? 4'h0 : wcnt + {3'h0, psel && penable};
			if (pready && pwrite && i == 16'hFE11)
				div <= pwdata[7:6];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("long pready");
	property p_err; pready |-> pslverr == !ok; endproperty
	a_err: assert property (p_err) else $error("bad decode");
	property p_wait; pready |-> wcnt == 1 || (wcnt == 9 && usr && !pwrite);
	endproperty
	a_wait: assert property (p_wait) else $error("bad wait");
	property p_il; rdc |-> !(prdata[0] && prdata[1]); endproperty
	a_il: assert property (p_il) else $error("both modes set");
	property p_mrg; rdc |-> !(prdata[2] && prdata[3]); endproperty
	a_mrg: assert property (p_mrg) else $error("margin with hv");
	property p_hv; rdc && prdata[3] |-> prdata[0] || prdata[1]; endproperty
	a_hv: assert property (p_hv) else $error("hv without mode");
	property p_rise; $rose(high_voltage_on) |->
		$past(pready && pwrite && i == 16'hFE11 && pwdata[3], 2); endproperty
	a_rise: assert property (p_rise) else $error("hv rose alone");
	property p_tick; pump_tick |-> high_voltage_on || $past(high_voltage_on);
	endproperty
	a_tick: assert property (p_tick) else $error("tick with hv off");
	property p_div1; (div == 2'h0 && high_voltage_on) [*2] |-> pump_tick;
	endproperty
	a_div1: assert property (p_div1) else $error("divide 1");
	property p_div2; pump_tick && div[0] != div[1] |=> !pump_tick ##1
		(pump_tick || !high_voltage_on); endproperty
	a_div2: assert property (p_div2) else $error("divide 2");
	property p_div4; pump_tick && div == 2'h3 |=> !pump_tick [*3] ##1
		(pump_tick || !high_voltage_on); endproperty
	a_div4: assert property (p_div4) else $error("divide 4");
endmodule

bind fpec_top fpec_properties u_props (.sys_clk, .rst_b, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .protect_byte,
	.high_voltage_on, .pump_tick);

//--- verification/fpec_top_test.sv
// Self-checking bench for the flash array control block
`timescale 1ns/1ns
`include "fpec_regs.vh"
module fpec_top_test;
	localparam [15:0] C = `FPEC_IDX_CTRL;
	localparam [15:0] P = `FPEC_IDX_PROT;
	localparam [32:0] ERR = 33'h100000000;
	localparam [32:0] ALL = 33'h1FFFFFFFF;
	reg         sys_clk = 1'b0;
	reg         rst_b = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [17:0] paddr = 18'h0;
	reg  [31:0] pwdata = 32'h0;
	reg  [7:0]  protect_byte = 8'h00;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        high_voltage_on;
	wire        pump_tick;
	integer     n_fail = 0;
	integer     n_checks = 0;
	integer     seed = 32'hd9935be2;
	integer     i;
	integer     k;
	reg  [7:0]  c;
	reg  [7:0]  dat [0:7];
	reg  [15:0] t;
	reg  [32:0] eq [$];
	reg  [32:0] mq [$];
	reg  [32:0] e;

	always #50 sys_clk = ~sys_clk;

	fpec_top dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .protect_byte,
		.high_voltage_on, .pump_tick);

	task xfer(input w, input [15:0] a, input [7:0] d, input [32:0] x,
		input [32:0] m);
		begin
			eq.push_back(x);
			mq.push_back(m);
			@(posedge sys_clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= {a, 2'b00};
			pwdata <= {24'h0, d};
			@(posedge sys_clk);
			penable <= 1'b1;
			@(posedge sys_clk);
			while (pready !== 1'b1)
				@(posedge sys_clk);
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task wr(input [15:0] a, input [7:0] d);
		xfer(1'b1, a, d, 33'h0, ALL);
	endtask

	task rd(input [15:0] a, input [7:0] v);
		xfer(1'b0, a, 8'h00, {25'h0, v}, ALL);
	endtask

	task chk(input got, input x);
		begin
			n_checks = n_checks + 1;
			if (got !== x) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, x);
			end
		end
	endtask

	// Results come back in request order, so the eq and mq queues pair them
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) begin
			e = eq.pop_front();
			n_checks = n_checks + 1;
			if ((({pslverr, prdata} ^ e) & mq.pop_front()) !== 33'h0) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time,
					{pslverr, prdata}, e);
			end
		end
	end

	task test_done;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_fail);
			if (n_fail == 0 && n_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	initial begin
		repeat (80000) @(posedge sys_clk);
		n_fail = n_fail + 1;
		test_done;
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(C, 8'h00);
		rd(`FPEC_IDX_STAT, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			t = i == 0 ? 16'h044F : i == 1 ? 16'h0500 : i == 2 ? 16'h8000 : 16'hFE10;
			xfer(1'b0, t, 8'h00, ERR, ERR);
			t = i == 0 ? 16'h04FF : i == 1 ? 16'h0580 : i == 2 ? 16'h0E00 : 16'h7FFF;
			xfer(1'b0, t, 8'h00, 33'h0, ERR);
			k = $random(seed);
			c = {k[7:4], 4'h0};
			wr(C, c);
			rd(C, c);
		end
		wr(C, 8'h01);
		wr(C, 8'h03);
		rd(C, 8'h01);
		wr(C, 8'h08);
		rd(C, 8'h00);
		wr(C, 8'h02);
		wr(C, 8'h0A);
		rd(C, 8'h02);
		rd(`FPEC_IDX_STAT, 8'h08);
		wr(`FPEC_IDX_STAT, 8'h08);
		rd(`FPEC_IDX_STAT, 8'h00);
		// Row first: later reads rely on every array byte being erased
		for (i = 0; i < 4; i = i + 1) begin
			k = 3 - i;
			c = {k[1:0], k[1:0], 4'h2};
			t = i == 0 ? 16'h0E40 : i == 3 ? 16'h0450 : 16'h0E00;
			wr(C, c);
			rd(P, 8'h00);
			wr(t, 8'hA5);
			wr(C, c | 8'h08);
			repeat (2) @(negedge sys_clk);
			chk(high_voltage_on, 1'b1);
			wr(C, c | 8'h0C);
			rd(C, c | 8'h08);
			repeat (i == 3 ? 33000 : i == 2 ? 16500 : i == 1 ? 600 : 100)
				@(posedge sys_clk);
			wr(C, c);
			repeat (2) @(negedge sys_clk);
			chk(high_voltage_on, 1'b0);
			wr(C, c & 8'hF0);
			rd(t, 8'h00);
			rd(t + 16'h003F, 8'h00);
		end
		wr(C, 8'h01);
		rd(P, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			k = $random(seed);
			dat[i] = k[7:0];
			wr(16'h0E40 + i[15:0], dat[i]);
		end
		wr(C, 8'h09);
		repeat (2) @(negedge sys_clk);
		chk(high_voltage_on, 1'b1);
		repeat (20) @(posedge sys_clk);
		wr(C, 8'h01);
		wr(C, 8'h05);
		wr(C, 8'h04);
		for (i = 0; i < 9; i = i + 1)
			rd(16'h0E40 + i[15:0], i < 8 ? dat[i] : 8'h00);
		wr(C, 8'h00);
		k = $random(seed);
		protect_byte <= 8'h01 << k[1:0];
		wr(C, 8'h02);
		rd(P, 8'h01 << k[1:0]);
		wr(16'h7FC0, 8'h00);
		rd(C, 8'h02);
		wr(C, 8'h0A);
		rd(C, 8'h00);
		protect_byte <= 8'h08;
		wr(C, 8'h32);
		rd(P, 8'h08);
		wr(16'h0E40, 8'h00);
		rd(C, 8'h32);
		wr(C, 8'h3A);
		rd(C, 8'h3A);
		test_done;
	end
endmodule
